// ===== tfmc_core.sv
// Thyristor firing mode control: burst and phase scheduling with registers
`timescale 1ns/1ns
module tfmc_core
  import tfmc_pkg::*;
#(
  parameter int CS_CLKS   = int'(TFMC_CS_CLKS),
  parameter int PWM_TICKS = int'(TFMC_PWM_MAX_TICKS)
)(
  // Clock and reset
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rst_n,
  // Mains, load and PWM demand pins
  input  wire logic                   i_zero_cross,
  input  wire logic                   i_over_limit,
  input  wire logic                   i_pwm_pin,
  // Register port
  input  wire logic [TFMC_ADDR_W-1:0] i_addr,
  input  wire logic [TFMC_DATA_W-1:0] i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [TFMC_DATA_W-1:0] o_rdata,
  // Gate drive and applied demand
  output logic                        o_fire,
  output logic      [6:0]             o_demand
);
  logic [2:0]  cross_reg, cross_next, ov_reg, ov_next;
  logic [19:0] hc_cnt_reg, hc_cnt_next, hc_len_reg, hc_len_next;
  logic        half_reg, half_next, cross_edge, over, boundary;
  logic [17:0] cs_tick_reg, cs_tick_next;
  logic [14:0] cs_reg, cs_next;
  logic [7:0]  ctrl_reg, ctrl_next, burst_reg, burst_next, delay_reg, delay_next;
  logic [6:0]  dem_reg, dem_next, cap_reg, cap_next, pwm_dem;
  logic [3:0]  min_on_reg, min_on_next;
  logic [15:0] shut_reg, shut_next, off_reg, off_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [6:0]  app_reg, app_next, ramp_reg, ramp_next, src, capped, eff;
  logic        slot_reg, slot_next, first_reg, first_next, fire_reg, fire_next, fire_ok;
  logic [3:0]  left_reg, left_next;
  logic signed [11:0] acc_reg, acc_next, acc_sum;
  tfmc_mode_type mode;
  logic        soft_en, lim_en, pwm_sel;

  assign mode    = tfmc_mode_type'(ctrl_reg[TFMC_CTRL_MODE_LSB +: 2]);
  assign soft_en = ctrl_reg[TFMC_CTRL_SOFT_BIT];
  assign lim_en  = ctrl_reg[TFMC_CTRL_LIM_BIT];
  assign pwm_sel = (ctrl_reg[TFMC_CTRL_IFS_LSB +: 4] == TFMC_IFS_PWM);
  assign o_rdata  = rdata_reg;
  assign o_fire   = fire_reg;
  assign o_demand = app_reg;

  // Duty measurement of the digital demand input
  tfmc_pwm_meter #(
    .TICK_CLKS (int'(TFMC_PWM_TICK_CLKS)),
    .MAX_TICKS (PWM_TICKS)
  ) u_meter (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_pwm_pin (i_pwm_pin),
    .o_demand  (pwm_dem)
  );

  // Pin synchronisers, half-cycle length and centisecond time base
  assign cross_edge = cross_reg[1] & ~cross_reg[2];
  assign over    = ov_reg[1];
  assign boundary = cross_edge && ((mode == TFMC_HALF) || half_reg);
  always_comb
  begin
    cross_next   = {cross_reg[1:0], i_zero_cross};
    ov_next      = {ov_reg[1:0], i_over_limit};
    hc_cnt_next  = cross_edge ? 20'h00000 :
                   (&hc_cnt_reg ? hc_cnt_reg : hc_cnt_reg + 20'h00001);
    hc_len_next  = cross_edge ? hc_cnt_reg : hc_len_reg;
    half_next    = cross_edge ? ~half_reg : half_reg;
    cs_tick_next = (cs_tick_reg == 18'(CS_CLKS - 1)) ? 18'h00000 : cs_tick_reg + 18'h00001;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cross_reg   <= 3'h0;
      ov_reg      <= 3'h0;
      hc_cnt_reg  <= 20'h00000;
      hc_len_reg  <= 20'h00000;
      half_reg    <= 1'b0;
      cs_tick_reg <= 18'h00000;
    end
    else
    begin
      cross_reg   <= cross_next;
      ov_reg      <= ov_next;
      hc_cnt_reg  <= hc_cnt_next;
      hc_len_reg  <= hc_len_next;
      half_reg    <= half_next;
      cs_tick_reg <= cs_tick_next;
    end
  end

  // Register writes with range clamps and registered read data
  always_comb
  begin
    ctrl_next   = ctrl_reg;
    dem_next    = dem_reg;
    burst_next  = burst_reg;
    min_on_next = min_on_reg;
    delay_next  = delay_reg;
    cap_next    = cap_reg;
    shut_next   = shut_reg;
    rdata_next  = 16'h0000;
    if (i_wr)
    begin
      case (i_addr)
        TFMC_REG_CTRL:    ctrl_next = i_wdata[7:0];
        TFMC_REG_DEMAND:  dem_next = (i_wdata > 16'(TFMC_PCT_FULL)) ? TFMC_PCT_FULL : i_wdata[6:0];
        TFMC_REG_BURST:   burst_next = (i_wdata < 16'(TFMC_BURST_MIN)) ? TFMC_BURST_MIN :
                                       (i_wdata > 16'(TFMC_BURST_MAX)) ? TFMC_BURST_MAX :
                                       i_wdata[7:0];
        TFMC_REG_MIN_ON:  min_on_next = (i_wdata < 16'(TFMC_MINON_MIN)) ? TFMC_MINON_MIN :
                                        (i_wdata > 16'(TFMC_MINON_MAX)) ? TFMC_MINON_MAX :
                                        i_wdata[3:0];
        TFMC_REG_DELAY:   delay_next = (i_wdata > 16'(TFMC_DELAY_MAX)) ? TFMC_DELAY_MAX :
                                       i_wdata[7:0];
        TFMC_REG_CAP:     cap_next = (i_wdata > 16'(TFMC_PCT_FULL)) ? TFMC_PCT_FULL : i_wdata[6:0];
        TFMC_REG_SHUTOFF: shut_next = i_wdata;
        default: ;
      endcase
    end
    if (i_rd)
    begin
      case (i_addr)
        TFMC_REG_CTRL:    rdata_next = {8'h00, ctrl_reg};
        TFMC_REG_DEMAND:  rdata_next = {9'h000, dem_reg};
        TFMC_REG_BURST:   rdata_next = {8'h00, burst_reg};
        TFMC_REG_MIN_ON:  rdata_next = {12'h000, min_on_reg};
        TFMC_REG_DELAY:   rdata_next = {8'h00, delay_reg};
        TFMC_REG_CAP:     rdata_next = {9'h000, cap_reg};
        TFMC_REG_SHUTOFF: rdata_next = shut_reg;
        TFMC_REG_STATUS:  rdata_next = {fire_reg, slot_reg, over, 6'h00, app_reg};
        TFMC_REG_PWM:     rdata_next = {9'h000, pwm_dem};
        default:          rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctrl_reg   <= 8'h00;
      dem_reg    <= 7'h00;
      burst_reg  <= TFMC_BURST_MIN;
      min_on_reg <= TFMC_MINON_MIN;
      delay_reg  <= 8'h00;
      cap_reg    <= TFMC_PCT_FULL;
      shut_reg   <= TFMC_SHUTOFF_RST;
      rdata_reg  <= 16'h0000;
    end
    else
    begin
      ctrl_reg   <= ctrl_next;
      dem_reg    <= dem_next;
      burst_reg  <= burst_next;
      min_on_reg <= min_on_next;
      delay_reg  <= delay_next;
      cap_reg    <= cap_next;
      shut_reg   <= shut_next;
      rdata_reg  <= rdata_next;
    end
  end

  // Demand source, RMS cap and soft-start ramp
  always_comb
  begin
    src    = pwm_sel ? pwm_dem : dem_reg;
    capped = (lim_en && over && src > cap_reg) ? cap_reg : src;
    eff    = (soft_en && capped > ramp_reg) ? ramp_reg : capped;
  end

  // Burst and phase scheduling, taken only at cycle boundaries, or at every half-cycle in half mode
  assign acc_sum = acc_reg + 12'(app_next);
  always_comb
  begin
    app_next   = app_reg;
    ramp_next  = ramp_reg;
    off_next   = off_reg;
    slot_next  = slot_reg;
    first_next = cross_edge ? 1'b0 : first_reg;
    left_next  = left_reg;
    acc_next   = acc_reg;
    cs_next    = (cs_tick_reg == 18'(CS_CLKS - 1)) ? cs_reg + 15'h0001 : cs_reg;
    if (boundary)
    begin
      app_next = eff;
      off_next = (capped != 7'h00) ? 16'h0000 : (&off_reg ? off_reg : off_reg + 16'h0001);
      if (off_reg > shut_reg)
        ramp_next = 7'h00;
      else if (ramp_reg < capped && !over)
        ramp_next = ramp_reg + 7'h01;
      case (mode)
        TFMC_FIXED:
        begin
          if (cs_reg >= 15'(burst_reg) * 15'(TFMC_PCT_FULL))
            cs_next = 15'h0000;
          slot_next = (cs_next < 15'(burst_reg) * 15'(app_next));
        end
        TFMC_VARIABLE, TFMC_HALF:
        begin
          if (left_reg != 4'h0)
          begin
            slot_next = 1'b1;
            left_next = left_reg - 4'h1;
            acc_next  = acc_sum - 12'(TFMC_PCT_FULL);
          end
          else if (acc_sum >= $signed(12'(TFMC_PCT_FULL)))
          begin
            slot_next = 1'b1;
            left_next = (mode == TFMC_HALF) ? 4'h0 : min_on_reg - 4'h1;
            acc_next  = acc_sum - 12'(TFMC_PCT_FULL);
          end
          else
          begin
            slot_next = 1'b0;
            acc_next  = acc_sum;
          end
        end
        default: slot_next = (app_next != 7'h00);
      endcase
      first_next = slot_next && !slot_reg && (mode == TFMC_FIXED || mode == TFMC_VARIABLE);
    end
    if (ctrl_next[TFMC_CTRL_MODE_LSB + 1])
      first_next = 1'b0; // Half or phase mode about to apply
  end

  // Firing point inside the half-cycle
  always_comb
  begin
    if (mode == TFMC_PHASE)
      fire_ok = 27'(hc_cnt_reg) * 27'(TFMC_PCT_FULL) >=
                27'(hc_len_reg) * 27'(TFMC_PCT_FULL - app_reg);
    else if (first_reg)
      fire_ok = 28'(hc_cnt_reg) * 28'(TFMC_DEG_HALF) >=
                28'(hc_len_reg) * 28'(delay_reg);
    else
      fire_ok = 1'b1;
    fire_next = slot_reg && fire_ok && !cross_edge;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      app_reg   <= 7'h00;
      ramp_reg  <= 7'h00;
      off_reg   <= 16'h0000;
      slot_reg  <= 1'b0;
      first_reg <= 1'b0;
      left_reg  <= 4'h0;
      acc_reg   <= 12'sh000;
      cs_reg    <= 15'h0000;
      fire_reg  <= 1'b0;
    end
    else
    begin
      app_reg   <= app_next;
      ramp_reg  <= ramp_next;
      off_reg   <= off_next;
      slot_reg  <= slot_next;
      first_reg <= first_next;
      left_reg  <= left_next;
      acc_reg   <= acc_next;
      cs_reg    <= cs_next;
      fire_reg  <= fire_next;
    end
  end

  // Checks on scheduling and firing
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  property p_fire_slot;
    o_fire |-> $past(slot_reg);
  endproperty
  a_fire_slot: assert property (p_fire_slot) else $error("fired outside slot");
  property p_zero_off;
    boundary && eff == 7'h00 && mode != TFMC_PHASE && left_reg == 4'h0 |=> !slot_reg;
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("slot on at zero demand");
  property p_full_on;
    boundary && eff == TFMC_PCT_FULL && mode == TFMC_VARIABLE |=> slot_reg;
  endproperty
  a_full_on: assert property (p_full_on) else $error("slot off at full demand");
  property p_min_run;
    boundary && mode == TFMC_VARIABLE && !slot_reg && slot_next
      |=> left_reg == $past(min_on_reg) - 4'h1;
  endproperty
  a_min_run: assert property (p_min_run) else $error("minimum run not loaded");
  property p_half_step;
    mode == TFMC_HALF && cross_edge |-> boundary;
  endproperty
  a_half_step: assert property (p_half_step) else $error("half-cycle step missed");
  property p_phase_fire;
    mode == TFMC_PHASE && slot_reg && !cross_edge && app_reg == TFMC_PCT_FULL |=> o_fire;
  endproperty
  a_phase_fire: assert property (p_phase_fire) else $error("full phase not fired");
  property p_ramp_step;
    ramp_reg != 7'h00 |-> ramp_reg <= $past(ramp_reg) + 7'h01;
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("ramp jumped");
  property p_shutoff;
    boundary && off_reg > shut_reg |=> ramp_reg == 7'h00;
  endproperty
  a_shutoff: assert property (p_shutoff) else $error("ramp not restarted");
  property p_limit;
    boundary && lim_en && over |=> app_reg <= $past(cap_reg);
  endproperty
  a_limit: assert property (p_limit) else $error("limit not applied");
  property p_delay_modes;
    first_reg |-> mode == TFMC_FIXED || mode == TFMC_VARIABLE;
  endproperty
  a_delay_modes: assert property (p_delay_modes) else $error("delay in wrong mode");
  property p_src_sel;
    boundary && !pwm_sel && !soft_en && !lim_en |=> app_reg == $past(dem_reg);
  endproperty
  a_src_sel: assert property (p_src_sel) else $error("wrong demand source");
  property p_hold;
    !boundary |=> $stable(app_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("demand changed mid cycle");
  c_fixed_on: cover property (mode == TFMC_FIXED && boundary ##1 slot_reg);
  c_var_burst: cover property (mode == TFMC_VARIABLE && slot_reg && left_reg != 4'h0);
  c_phase_fire: cover property (mode == TFMC_PHASE && $rose(o_fire));
  c_delay_fire: cover property (first_reg && $rose(o_fire));
endmodule

// ===== tfmc_pkg.sv
// Shared constants and types for the thyristor firing mode control block
package tfmc_pkg;
  // Register port widths
  localparam int TFMC_ADDR_W = 4;
  localparam int TFMC_DATA_W = 16;
  // Register word offsets
  localparam logic [3:0] TFMC_REG_CTRL    = 4'h0;
  localparam logic [3:0] TFMC_REG_DEMAND  = 4'h1;
  localparam logic [3:0] TFMC_REG_BURST   = 4'h2;
  localparam logic [3:0] TFMC_REG_MIN_ON  = 4'h3;
  localparam logic [3:0] TFMC_REG_DELAY   = 4'h4;
  localparam logic [3:0] TFMC_REG_CAP     = 4'h5;
  localparam logic [3:0] TFMC_REG_SHUTOFF = 4'h6;
  localparam logic [3:0] TFMC_REG_STATUS  = 4'h7;
  localparam logic [3:0] TFMC_REG_PWM     = 4'h8;
  // Control register field positions
  localparam int TFMC_CTRL_MODE_LSB = 0;
  localparam int TFMC_CTRL_SOFT_BIT = 2;
  localparam int TFMC_CTRL_LIM_BIT  = 3;
  localparam int TFMC_CTRL_IFS_LSB  = 4;
  // Firing modes
  typedef enum logic [1:0] {
    TFMC_FIXED    = 2'h0,
    TFMC_VARIABLE = 2'h1,
    TFMC_HALF     = 2'h2,
    TFMC_PHASE    = 2'h3
  } tfmc_mode_type;
  // Input function code that selects the PWM demand source
  localparam logic [3:0] TFMC_IFS_PWM = 4'h7;
  // Percent and angle figures, burst and minimum-run limits
  localparam logic [6:0] TFMC_PCT_FULL  = 7'h64;
  localparam logic [7:0] TFMC_DEG_HALF  = 8'hb4;
  localparam logic [7:0] TFMC_DELAY_MAX = 8'h5a;
  localparam logic [7:0] TFMC_BURST_MIN = 8'h01;
  localparam logic [7:0] TFMC_BURST_MAX = 8'hc8;
  localparam logic [3:0] TFMC_MINON_MIN = 4'h1;
  localparam logic [3:0] TFMC_MINON_MAX = 4'ha;
  // Reset values
  localparam logic [15:0] TFMC_SHUTOFF_RST = 16'h0032;
  // Timing: clock rate, centisecond tick, PWM sampling tick, slowest PWM rate
  localparam longint TFMC_CLK_HZ      = 25000000;
  localparam longint TFMC_CS_TIME_MS  = 10;
  localparam longint TFMC_CS_CLKS     = TFMC_CLK_HZ * TFMC_CS_TIME_MS / 1000;
  localparam longint TFMC_PWM_TICK_US = 100;
  localparam longint TFMC_PWM_TICK_CLKS = TFMC_CLK_HZ * TFMC_PWM_TICK_US / 1000000;
  localparam longint TFMC_PWM_MIN_MHZ = 30;
  localparam longint TFMC_PWM_MAX_TICKS =
    (1000000 / TFMC_PWM_TICK_US) * 1000 / TFMC_PWM_MIN_MHZ;
  // PWM measurement states
  typedef enum logic [1:0] {
    TFMC_MEAS = 2'b01,
    TFMC_DIV  = 2'b10
  } tfmc_meter_type;
endpackage

// ===== tfmc_pwm_meter.sv
// PWM demand meter: duty ratio of the digital input in percent
`timescale 1ns/1ns
module tfmc_pwm_meter
  import tfmc_pkg::*;
#(
  parameter int TICK_CLKS = int'(TFMC_PWM_TICK_CLKS),
  parameter int MAX_TICKS = int'(TFMC_PWM_MAX_TICKS)
)(
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  // Demand pin from the external controller
  input  wire logic       i_pwm_pin,
  // Measured demand
  output logic      [6:0] o_demand
);
  logic [2:0]     sync_reg, sync_next;
  logic [11:0]    tick_reg, tick_next;
  logic [19:0]    high_reg, high_next, low_reg, low_next;
  logic [26:0]    rem_reg, rem_next;
  logic [19:0]    den_reg, den_next;
  logic [6:0]     q_reg, q_next, dem_reg, dem_next;
  tfmc_meter_type st_reg, st_next;
  logic           tick, rise;

  assign tick = (tick_reg == 12'(TICK_CLKS - 1));
  assign rise = sync_reg[1] & ~sync_reg[2];
  assign o_demand = dem_reg;

  // High and low times in ticks; divide at a rising edge when both are non-zero
  always_comb
  begin
    sync_next = {sync_reg[1:0], i_pwm_pin};
    tick_next = tick ? 12'h000 : tick_reg + 12'h001;
    high_next = high_reg;
    low_next  = low_reg;
    rem_next  = rem_reg;
    den_next  = den_reg;
    q_next    = q_reg;
    dem_next  = dem_reg;
    st_next   = st_reg;
    if (tick && (high_reg + low_reg) < 20'(MAX_TICKS))
    begin
      if (sync_reg[2])
        high_next = high_reg + 20'h00001;
      else
        low_next = low_reg + 20'h00001;
    end
    // Period tracks itself; no edge within the slowest period means a steady level
    if ((high_reg + low_reg) >= 20'(MAX_TICKS))
      dem_next = sync_reg[2] ? TFMC_PCT_FULL : 7'h00;
    case (st_reg)
      TFMC_MEAS:
      begin
        if (rise)
        begin
          high_next = 20'h00000;
          low_next  = 20'h00000;
          if (high_reg != 20'h00000 && low_reg != 20'h00000)
          begin
            rem_next = 27'(high_reg) * 27'(TFMC_PCT_FULL); // High over high plus low
            den_next = high_reg + low_reg;
            q_next   = 7'h00;
            st_next  = TFMC_DIV;
          end
        end
      end
      TFMC_DIV:
      begin
        if (rem_reg >= 27'(den_reg))
        begin
          rem_next = rem_reg - 27'(den_reg);
          q_next   = q_reg + 7'h01;
        end
        else
        begin
          dem_next = q_reg;
          st_next  = TFMC_MEAS;
        end
      end
      default: st_next = TFMC_MEAS;
    endcase
  end

  // State registers
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync_reg <= 3'h0;
      tick_reg <= 12'h000;
      high_reg <= 20'h00000;
      low_reg  <= 20'h00000;
      rem_reg  <= 27'h0000000;
      den_reg  <= 20'h00000;
      q_reg    <= 7'h00;
      dem_reg  <= 7'h00;
      st_reg   <= TFMC_MEAS;
    end
    else
    begin
      sync_reg <= sync_next;
      tick_reg <= tick_next;
      high_reg <= high_next;
      low_reg  <= low_next;
      rem_reg  <= rem_next;
      den_reg  <= den_next;
      q_reg    <= q_next;
      dem_reg  <= dem_next;
      st_reg   <= st_next;
    end
  end

  // Measured demand never passes full scale
  property p_pwm_range;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      dem_reg <= TFMC_PCT_FULL;
  endproperty
  a_pwm_range: assert property (p_pwm_range) else $error("pwm demand above full");
endmodule

// ===== tfmc_pwm_src.sv
// Model of the external controller that drives the PWM demand pin
`timescale 1ns/1ns
module tfmc_pwm_src
#(
  parameter int HIGH_CLKS = 10000,
  parameter int LOW_CLKS  = 10000
)(
  // Clock and enable
  input  wire logic i_ref_clk,
  input  wire logic i_en,
  // Demand pin
  output logic      o_pwm = 1'b0
);
  int cnt = 0;
  // Constant period: a high interval, then a low interval
  always @(posedge i_ref_clk)
  begin
    if (!i_en)
    begin
      cnt   <= 0;
      o_pwm <= 1'b0;
    end
    else
    begin
      cnt   <= (cnt == HIGH_CLKS + LOW_CLKS - 1) ? 0 : cnt + 1;
      o_pwm <= (cnt < HIGH_CLKS);
    end
  end
endmodule

// ===== tfmc_core_tb.sv
// Self-checking testbench for the thyristor firing mode control core
`timescale 1ns/1ns
module tfmc_core_tb;
  import tfmc_pkg::*;
  // Design connections
  logic                   i_ref_clk    = 1'b0;
  logic                   i_rst_n      = 1'b0;
  logic                   i_zero_cross = 1'b0;
  logic                   i_over_limit = 1'b0;
  logic                   i_pwm_pin;
  logic [TFMC_ADDR_W-1:0] i_addr       = '0;
  logic [TFMC_DATA_W-1:0] i_wdata      = '0;
  logic                   i_wr         = 1'b0;
  logic                   i_rd         = 1'b0;
  logic [TFMC_DATA_W-1:0] o_rdata;
  logic                   o_fire;
  logic [6:0]             o_demand;
  // Bench state
  logic                   pwm_en       = 1'b0;
  logic [TFMC_DATA_W-1:0] rd_val;
  int                     n_mismatch   = 0;
  int                     checks       = 0;
  int                     cyc          = 0;
  int                     mains_cnt    = 0;
  int                     n_high       = 0;
  int                     n_burst      = 0;
  int                     low_run      = 0;
  localparam int          PWM_HALF     = 4 * int'(TFMC_PWM_TICK_CLKS);

  tfmc_core #(.CS_CLKS(10), .PWM_TICKS(1000)) i_dut (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_zero_cross(i_zero_cross),
    .i_over_limit(i_over_limit), .i_pwm_pin(i_pwm_pin), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_fire(o_fire), .o_demand(o_demand));
  tfmc_pwm_src #(.HIGH_CLKS(PWM_HALF), .LOW_CLKS(PWM_HALF)) i_pwm (
    .i_ref_clk(i_ref_clk), .i_en(pwm_en), .o_pwm(i_pwm_pin));

  // Clock and mains crossings, one crossing every 50 clocks
  always #20 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk)
  begin
    mains_cnt    <= (mains_cnt == 49) ? 0 : mains_cnt + 1;
    i_zero_cross <= (mains_cnt < 10);
  end
  // Gate monitor: high time, burst starts after a long gap, cycle ceiling
  always @(posedge i_ref_clk)
  begin
    cyc = cyc + 1;
    if (o_fire === 1'b1)
    begin
      if (low_run > 20)
        n_burst = n_burst + 1;
      n_high  = n_high + 1;
      low_run = 0;
    end
    else
      low_run = low_run + 1;
    if (cyc == 100000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  // Verdict and end of run
  task automatic complete_run();
    if (n_mismatch == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Register port cycles
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a);
    @(posedge i_ref_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 rd_val = o_rdata;
  endtask
  // Comparisons: exact value and range
  task automatic chk_eq(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [15:0] got, input int lo, input int hi);
    checks++;
    if (((got >= lo) && (got <= hi)) !== 1'b1)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic measure(input int n);
    n_high  = 0;
    n_burst = 0;
    wait_clk(n);
  endtask
  task automatic wait_fire(input logic v);
    for (int i = 0; i < 100 && o_fire !== v; i++)
    begin
      @(posedge i_ref_clk);
      #1;
    end
  endtask
  // Reset values and an unmapped read
  task automatic t_regs();
    logic [3:0]  ra [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9};
    logic [15:0] rv [8] = '{16'h0, 16'h0, 16'h1, 16'h1, 16'h0, 16'h64, 16'h32, 16'h0};
    for (int k = 0; k < 8; k++)
    begin
      reg_rd(ra[k]);
      chk_eq(rd_val, rv[k]);
    end
  endtask
  // Soft start ramps the applied demand from zero; a long off time restarts it
  task automatic t_soft();
    reg_wr(4'h1, 16'h5);
    reg_wr(4'h0, 16'h7); // soft start and no delay in phase mode
    wait_clk(250);
    chk_rng(16'(o_demand), 1, 3);
    wait_clk(1000);
    chk_eq(16'(o_demand), 16'h5);
    reg_wr(4'h6, 16'h2);
    reg_wr(4'h1, 16'h0);
    wait_clk(600);
    chk_eq(16'(o_demand), 16'h0);
    reg_wr(4'h1, 16'h5);
    wait_clk(350);
    chk_rng(16'(o_demand), 1, 3);
  endtask
  // Out-of-range settings are clamped
  task automatic t_clamp();
    logic [3:0]  wa [5] = '{4'h1, 4'h2, 4'h2, 4'h3, 4'h4};
    logic [15:0] wv [5] = '{16'hc8, 16'h0, 16'hfa, 16'hf, 16'h78};
    logic [15:0] we [5] = '{16'h64, 16'h1, 16'hc8, 16'ha, 16'h5a};
    for (int k = 0; k < 5; k++)
    begin
      reg_wr(wa[k], wv[k]);
      reg_rd(wa[k]);
      chk_eq(rd_val, we[k]);
    end
  endtask
  // Phase angle follows demand; a new demand waits for a boundary
  task automatic t_phase();
    reg_wr(4'h0, 16'h3);
    reg_wr(4'h1, 16'h64);
    wait_clk(300);
    measure(400);
    chk_rng(16'(n_high), 380, 400);
    wait_fire(1'b1);
    wait_fire(1'b0);
    reg_wr(4'h1, 16'h32);
    chk_eq(16'(o_demand), 16'h64);
    wait_clk(300);
    chk_eq(16'(o_demand), 16'h32);
    measure(400);
    chk_rng(16'(n_high), 180, 220);
  endtask
  // Fixed one-second burst period at 30 percent
  task automatic t_fixed();
    reg_wr(4'h0, 16'h0);
    reg_wr(4'h2, 16'h1);
    reg_wr(4'h4, 16'h0);
    reg_wr(4'h1, 16'h1e);
    wait_clk(1200);
    measure(4400);
    chk_rng(16'(n_high), 1000, 1450);
    chk_rng(16'(n_burst), 3, 5);
  endtask
  // Variable period: minimum run of two, then one with delayed firing
  task automatic t_var();
    reg_wr(4'h0, 16'h1);
    reg_wr(4'h3, 16'h2);
    reg_wr(4'h1, 16'h32);
    wait_clk(800);
    measure(4000);
    chk_rng(16'(n_high), 1800, 2100);
    chk_rng(16'(n_burst), 9, 11);
    reg_wr(4'h3, 16'h1);
    reg_wr(4'h4, 16'h5a);
    wait_clk(800);
    measure(4000);
    chk_rng(16'(n_high), 1350, 1600);
    chk_rng(16'(n_burst), 19, 21);
  endtask
  // Half-cycle bursts at 33 percent
  task automatic t_half();
    reg_wr(4'h4, 16'h0);
    reg_wr(4'h0, 16'h2); // resistive load only
    reg_wr(4'h1, 16'h21); // demand kept above the minimum power limit
    wait_clk(500);
    measure(3000);
    chk_rng(16'(n_high), 880, 1080);
    chk_rng(16'(n_burst), 18, 21);
  endtask
  // Current limit caps the applied demand while over limit
  task automatic t_rms();
    reg_wr(4'h0, 16'hb);
    reg_wr(4'h5, 16'h14);
    reg_wr(4'h1, 16'h64);
    i_over_limit <= 1'b1;
    wait_clk(400);
    chk_eq(16'(o_demand), 16'h14);
    reg_rd(4'h7);
    chk_eq(rd_val & 16'h207f, 16'h2014);
    i_over_limit <= 1'b0;
    wait_clk(400);
    chk_eq(16'(o_demand), 16'h64);
  endtask
  // PWM demand source, then back to the register demand
  task automatic t_pwm();
    pwm_en <= 1'b1;
    reg_wr(4'h0, 16'h73);
    wait_clk(45000);
    reg_rd(4'h8);
    chk_rng(rd_val, 37, 63);
    chk_rng(16'(o_demand), 37, 63);
    reg_wr(4'h1, 16'ha);
    reg_wr(4'h0, 16'h63);
    wait_clk(300);
    chk_eq(16'(o_demand), 16'ha);
    pwm_en <= 1'b0;
  endtask

  // Main sequence
  initial
  begin
    wait_clk(10);
    i_rst_n <= 1'b1;
    t_regs();
    t_soft();
    t_clamp();
    t_phase();
    t_fixed();
    t_var();
    t_half();
    t_rms();
    t_pwm();
    complete_run();
  end
endmodule
